// ### qns_map.vh
// Register map, field positions and reset values for the CD quadrature
// correction and AB fine mixer shadow bank.
// Assumes an AHB-Lite slave with 32-bit words, index times four is the byte address.
// Function
// - CD phase correction: 12-bit two's complement in bits 11:0, resets to zero.
// - Active CD correction times D sample is added into C sample.
// - CD correction write with quadrature sync enabled loads all three CD registers.
// - Companion CD writes only update shadows until the auto-sync or a sync command.
// - AB offset adds to accumulator upper 16 bits to address sine tables.
// - AB offset write with mixer sync enabled loads offset and frequency word.
// - Frequency word writes leave active mixer settings unchanged until sync.
// - Frequency word is 32-bit two's complement from two 16-bit registers.
`ifndef QNS_MAP_VH
`define QNS_MAP_VH

// Register indices, byte address is four times the index
`define QNS_IDX_CD_GAIN_A 6'h0e
`define QNS_IDX_CD_GAIN_B 6'h0f
`define QNS_IDX_CD_PHASE 6'h11
`define QNS_IDX_AB_OFFSET 6'h12
`define QNS_IDX_AB_FREQ_LO 6'h14
`define QNS_IDX_AB_FREQ_HI 6'h15
`define QNS_IDX_QUAD_SYNC_EN 6'h1e
`define QNS_IDX_MIX_SYNC_EN 6'h1f
`define QNS_IDX_SYNC_CMD 6'h20
`define QNS_IDX_SYNC_STATUS 6'h21

// Byte address field of haddr that selects a word
`define QNS_ADDR_HI 7
`define QNS_ADDR_LO 2

// Field widths and positions
`define QNS_REG_W 16
`define QNS_PHASE_W 12
`define QNS_PHASE_FRAC 12
`define QNS_QUAD_BIT 0
`define QNS_MIX_BIT 1
`define QNS_SYNC_EN_BIT 0

// Reset values
`define QNS_RST_GAIN_A 16'h0000
`define QNS_RST_GAIN_B 16'h0400
`define QNS_RST_PHASE 12'h000
`define QNS_RST_ZERO16 16'h0000
`define QNS_RST_EN 1'h0
`define QNS_RST_IDX 6'h00
`define QNS_RST_ACC 32'h00000000

// NCO accumulator bits that form the table address
`define QNS_NCO_TOP_HI 31
`define QNS_NCO_TOP_LO 16

`endif

// ### qns_sync_reg.v
// One shadowed setting: software writes the shadow, a load copies it into
// the active copy that the datapath uses.
// Assumes one clock and an asynchronous active-low reset.
`default_nettype none
module qns_sync_reg #(
    parameter WIDTH = 16,
    parameter [WIDTH-1:0] RESET = {WIDTH{1'b0}}
) (
    input wire hclk,
    input wire hresetn,
    input wire wr_en,
    input wire [WIDTH-1:0] wr_data,
    input wire load,
    output reg [WIDTH-1:0] shadow,
    output reg [WIDTH-1:0] active
);
    // A load in the same cycle as a write takes the written value, so a
    // trigger write carries its own new value across
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shadow <= RESET;
            active <= RESET;
        end else begin
            if (wr_en)
                shadow <= wr_data;
            if (load)
                active <= wr_en ? wr_data : shadow;
        end
    end
endmodule // qns_sync_reg
`default_nettype wire

// ### qns_top.v
// AHB-Lite register bank with shadowed CD quadrature correction and AB
// fine mixer settings, plus the CD phase correction and AB phase address path.
// Assumes a single-slave bus, hclk samples everything, samples arrive with a valid strobe.
//
// Local design decision: the AHB-Lite slave port.
`default_nettype none
`include "qns_map.vh"
module qns_top #(
    parameter SAMPLE_W = 16
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire sample_valid,
    input wire [SAMPLE_W-1:0] c_sample,
    input wire [SAMPLE_W-1:0] d_sample,
    output reg [SAMPLE_W-1:0] c_corrected,
    output reg [SAMPLE_W-1:0] d_delayed,
    output reg [15:0] ab_lut_addr,
    output wire [15:0] cd_gain_offset_a_active,
    output wire [15:0] cd_gain_offset_b_active
);
    // Zero wait states and never an error
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    reg dp_write;
    reg dp_read;
    reg [5:0] dp_index;
    reg quad_sync_en;
    reg mix_sync_en;
    reg [31:0] rd_mux;

    wire addr_take;
    wire [15:0] wdata16;
    wire wr_gain_a;
    wire wr_gain_b;
    wire wr_phase;
    wire wr_offset;
    wire wr_freq_lo;
    wire wr_freq_hi;
    wire wr_cmd;
    wire cd_load;
    wire ab_load;
    wire [15:0] gain_a_sh;
    wire [15:0] gain_b_sh;
    wire [11:0] phase_sh;
    wire [11:0] phase_act;
    wire [15:0] offset_sh;
    wire [15:0] offset_act;
    wire [15:0] freq_lo_sh;
    wire [15:0] freq_lo_act;
    wire [15:0] freq_hi_sh;
    wire [15:0] freq_hi_act;

    // Address phase is taken only for an active transfer while the bus is ready
    assign addr_take = hsel & hready & htrans[1];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            dp_index <= `QNS_RST_IDX;
        end else if (hready) begin
            dp_write <= addr_take & hwrite;
            dp_read <= addr_take & ~hwrite;
            dp_index <= haddr[`QNS_ADDR_HI:`QNS_ADDR_LO];
        end
    end

    // Data-phase write strobes; hwdata is only valid in the data phase
    assign wdata16 = hwdata[`QNS_REG_W-1:0];
    assign wr_gain_a = dp_write & (dp_index == `QNS_IDX_CD_GAIN_A);
    assign wr_gain_b = dp_write & (dp_index == `QNS_IDX_CD_GAIN_B);
    assign wr_phase = dp_write & (dp_index == `QNS_IDX_CD_PHASE);
    assign wr_offset = dp_write & (dp_index == `QNS_IDX_AB_OFFSET);
    assign wr_freq_lo = dp_write & (dp_index == `QNS_IDX_AB_FREQ_LO);
    assign wr_freq_hi = dp_write & (dp_index == `QNS_IDX_AB_FREQ_HI);
    assign wr_cmd = dp_write & (dp_index == `QNS_IDX_SYNC_CMD);

    // Sync enables are plain stored bits
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quad_sync_en <= `QNS_RST_EN;
            mix_sync_en <= `QNS_RST_EN;
        end else begin
            if (dp_write & (dp_index == `QNS_IDX_QUAD_SYNC_EN))
                quad_sync_en <= hwdata[`QNS_SYNC_EN_BIT];
            if (dp_write & (dp_index == `QNS_IDX_MIX_SYNC_EN))
                mix_sync_en <= hwdata[`QNS_SYNC_EN_BIT];
        end
    end

    // Auto-sync on the trigger register, or a software sync command otherwise
    assign cd_load = (wr_phase & quad_sync_en)
        | (wr_cmd & hwdata[`QNS_QUAD_BIT]);
    assign ab_load = (wr_offset & mix_sync_en)
        | (wr_cmd & hwdata[`QNS_MIX_BIT]);

    // CD quadrature group: companions never load on their own writes
    qns_sync_reg #(.WIDTH(`QNS_REG_W), .RESET(`QNS_RST_GAIN_A)) u_gain_a (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(wr_gain_a),
        .wr_data(wdata16),
        .load(cd_load),
        .shadow(gain_a_sh),
        .active(cd_gain_offset_a_active)
    );
    qns_sync_reg #(.WIDTH(`QNS_REG_W), .RESET(`QNS_RST_GAIN_B)) u_gain_b (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(wr_gain_b),
        .wr_data(wdata16),
        .load(cd_load),
        .shadow(gain_b_sh),
        .active(cd_gain_offset_b_active)
    );
    // Only the low twelve bits are stored; the reserved top bits read zero
    qns_sync_reg #(.WIDTH(`QNS_PHASE_W), .RESET(`QNS_RST_PHASE)) u_phase (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(wr_phase),
        .wr_data(hwdata[`QNS_PHASE_W-1:0]),
        .load(cd_load),
        .shadow(phase_sh),
        .active(phase_act)
    );

    // AB fine mixer group
    qns_sync_reg #(.WIDTH(`QNS_REG_W), .RESET(`QNS_RST_ZERO16)) u_offset (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(wr_offset),
        .wr_data(wdata16),
        .load(ab_load),
        .shadow(offset_sh),
        .active(offset_act)
    );
    qns_sync_reg #(.WIDTH(`QNS_REG_W), .RESET(`QNS_RST_ZERO16)) u_freq_lo (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(wr_freq_lo),
        .wr_data(wdata16),
        .load(ab_load),
        .shadow(freq_lo_sh),
        .active(freq_lo_act)
    );
    qns_sync_reg #(.WIDTH(`QNS_REG_W), .RESET(`QNS_RST_ZERO16)) u_freq_hi (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(wr_freq_hi),
        .wr_data(wdata16),
        .load(ab_load),
        .shadow(freq_hi_sh),
        .active(freq_hi_act)
    );

    // Pending flags show shadows that differ from what the datapath uses
    wire cd_pending;
    wire ab_pending;
    assign cd_pending = (gain_a_sh != cd_gain_offset_a_active)
        | (gain_b_sh != cd_gain_offset_b_active) | (phase_sh != phase_act);
    assign ab_pending = (offset_sh != offset_act) | (freq_lo_sh != freq_lo_act)
        | (freq_hi_sh != freq_hi_act);

    // Read mux over stored flops; unmapped words and reserved bits read zero
    always @* begin
        rd_mux = 32'h00000000;
        case (dp_index)
            `QNS_IDX_CD_GAIN_A: rd_mux[`QNS_REG_W-1:0] = gain_a_sh;
            `QNS_IDX_CD_GAIN_B: rd_mux[`QNS_REG_W-1:0] = gain_b_sh;
            `QNS_IDX_CD_PHASE: rd_mux[`QNS_PHASE_W-1:0] = phase_sh;
            `QNS_IDX_AB_OFFSET: rd_mux[`QNS_REG_W-1:0] = offset_sh;
            `QNS_IDX_AB_FREQ_LO: rd_mux[`QNS_REG_W-1:0] = freq_lo_sh;
            `QNS_IDX_AB_FREQ_HI: rd_mux[`QNS_REG_W-1:0] = freq_hi_sh;
            `QNS_IDX_QUAD_SYNC_EN: rd_mux[`QNS_SYNC_EN_BIT] = quad_sync_en;
            `QNS_IDX_MIX_SYNC_EN: rd_mux[`QNS_SYNC_EN_BIT] = mix_sync_en;
            `QNS_IDX_SYNC_STATUS: begin
                rd_mux[`QNS_QUAD_BIT] = cd_pending;
                rd_mux[`QNS_MIX_BIT] = ab_pending;
            end
            default: rd_mux = 32'h00000000;
        endcase
    end
    assign hrdata = dp_read ? rd_mux : 32'h00000000;

    // CD phase correction: product of 12-bit fraction and D, scaled back to sample width
    wire signed [SAMPLE_W+`QNS_PHASE_W-1:0] cd_product;
    wire signed [SAMPLE_W-1:0] cd_term;
    wire signed [SAMPLE_W:0] cd_sum;
    wire signed [SAMPLE_W-1:0] sat_max;
    wire signed [SAMPLE_W-1:0] sat_min;
    assign cd_product = $signed(phase_act) * $signed(d_sample);
    assign cd_term = cd_product[`QNS_PHASE_FRAC+SAMPLE_W-1:`QNS_PHASE_FRAC];
    assign cd_sum = {c_sample[SAMPLE_W-1], c_sample} + {cd_term[SAMPLE_W-1], cd_term};
    assign sat_max = {1'b0, {(SAMPLE_W-1){1'b1}}};
    assign sat_min = {1'b1, {(SAMPLE_W-1){1'b0}}};

    // Saturate rather than wrap: a wrap would flip the sign of a full-scale sample
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            c_corrected <= {SAMPLE_W{1'b0}};
            d_delayed <= {SAMPLE_W{1'b0}};
        end else if (sample_valid) begin
            d_delayed <= d_sample;
            if (cd_sum[SAMPLE_W] != cd_sum[SAMPLE_W-1])
                c_corrected <= cd_sum[SAMPLE_W] ? sat_min : sat_max;
            else
                c_corrected <= cd_sum[SAMPLE_W-1:0];
        end
    end

    // AB NCO: 32-bit accumulator stepped by the active frequency word per sample
    reg [31:0] nco_acc;
    wire [31:0] freq_word;
    wire [15:0] next_lut_addr;
    assign freq_word = {freq_hi_act, freq_lo_act};
    assign next_lut_addr = nco_acc[`QNS_NCO_TOP_HI:`QNS_NCO_TOP_LO] + offset_act;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nco_acc <= `QNS_RST_ACC;
            ab_lut_addr <= `QNS_RST_ZERO16;
        end else if (sample_valid) begin
            nco_acc <= nco_acc + freq_word;
            ab_lut_addr <= next_lut_addr;
        end
    end
endmodule // qns_top
`default_nettype wire

// ### qns_chk_monitor.sv
// Checker for the CD shadow bank and the sample datapath of qns_top.
// Assumes one AHB-Lite master, hready tied to hreadyout, one clock.
`default_nettype none
`include "qns_map.vh"
module qns_chk #(
    parameter SAMPLE_W = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic sample_valid,
    input wire logic [SAMPLE_W-1:0] d_sample,
    input wire logic [SAMPLE_W-1:0] c_corrected,
    input wire logic [SAMPLE_W-1:0] d_delayed,
    input wire logic [15:0] ab_lut_addr,
    input wire logic [15:0] cd_gain_offset_a_active,
    input wire logic [15:0] cd_gain_offset_b_active
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr_q;
    logic [5:0] idx_q;
    logic q_en;
    logic [15:0] ga_sh;
    logic [15:0] gb_sh;
    // Mirror write data phases and the shadows they should fill
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            idx_q <= 6'h00;
            q_en <= 1'b0;
            ga_sh <= `QNS_RST_GAIN_A;
            gb_sh <= `QNS_RST_GAIN_B;
        end else begin
            wr_q <= hsel && hready && htrans[1] && hwrite;
            idx_q <= haddr[`QNS_ADDR_HI:`QNS_ADDR_LO];
            if (wr_q && idx_q == `QNS_IDX_QUAD_SYNC_EN) q_en <= hwdata[0];
            if (wr_q && idx_q == `QNS_IDX_CD_GAIN_A) ga_sh <= hwdata[15:0];
            if (wr_q && idx_q == `QNS_IDX_CD_GAIN_B) gb_sh <= hwdata[15:0];
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Trigger step: phase write lands while quadrature sync is on
    sequence cd_trig;
        wr_q && idx_q == `QNS_IDX_CD_PHASE && q_en;
    endsequence
    AST_TRIG_LOADS_A: assert property (cd_trig |=> cd_gain_offset_a_active == ga_sh)
        else $error("gain a not loaded by trigger");
    AST_TRIG_LOADS_B: assert property (cd_trig |=> cd_gain_offset_b_active == gb_sh)
        else $error("gain b not loaded by trigger");
    AST_A_WRITE_SHADOW: assert property (wr_q && idx_q == `QNS_IDX_CD_GAIN_A |=>
        $stable(cd_gain_offset_a_active)) else $error("gain a active moved on write");
    AST_B_WRITE_SHADOW: assert property (wr_q && idx_q == `QNS_IDX_CD_GAIN_B |=>
        $stable(cd_gain_offset_b_active)) else $error("gain b active moved on write");
    AST_ACTIVE_CAUSE: assert property ($changed(cd_gain_offset_a_active) |->
        $past(wr_q) && $past(idx_q) inside {`QNS_IDX_CD_PHASE, `QNS_IDX_SYNC_CMD})
        else $error("stray load");
    AST_C_HOLDS: assert property (!sample_valid |=> $stable(c_corrected))
        else $error("corrected c moved without sample");
    AST_D_ALIGN: assert property (sample_valid |=> d_delayed == $past(d_sample))
        else $error("delayed d misaligned");
    AST_LUT_HOLDS: assert property (!sample_valid |=> $stable(ab_lut_addr))
        else $error("lut address moved without sample");
endmodule // qns_chk
bind qns_top qns_chk #(.SAMPLE_W(SAMPLE_W)) u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hready, .hwdata, .sample_valid, .d_sample, .c_corrected, .d_delayed, .ab_lut_addr,
    .cd_gain_offset_a_active, .cd_gain_offset_b_active);
`default_nettype wire

// ### test_qmc_nco_shadow_autosync.sv
// Self-checking bench for qns_top: bus registers, CD shadows, datapath.
// Assumes the checker is bound in separately; the bench is the only master.
`default_nettype none
`include "qns_map.vh"
module test_qmc_nco_shadow_autosync;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, sample_valid;
    logic [31:0] haddr, hwdata, ga, gb, r, fr, off, acc;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] c_sample, d_sample;
    wire [31:0] hrdata;
    wire hreadyout, hresp;
    wire [15:0] c_corrected, d_delayed, ab_lut_addr, ga_act, gb_act;
    int errors, checks_done, seed, p, i;
    qns_top #(.SAMPLE_W(16)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sample_valid(sample_valid),
        .c_sample(c_sample), .d_sample(d_sample), .c_corrected(c_corrected),
        .d_delayed(d_delayed), .ab_lut_addr(ab_lut_addr), .cd_gain_offset_a_active(ga_act),
        .cd_gain_offset_b_active(gb_act));
    // 200 MHz clock
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // One single transfer; entered just after a rising edge; data sampled before the edge
    task automatic bus(input logic w, input logic [5:0] i, input logic [31:0] wd,
                       output logic [31:0] rd);
        logic rdy;
        hsel <= 1'b1; haddr <= {24'h000000, i, 2'b00}; htrans <= 2'b10; hwrite <= w;
        hsize <= 3'b010;
        do begin @(negedge hclk); rdy = hreadyout; @(posedge hclk); end while (rdy !== 1'b1);
        htrans <= 2'b00; hwdata <= wd;
        do begin
            @(negedge hclk); rdy = hreadyout; rd = hrdata; @(posedge hclk);
        end while (rdy !== 1'b1);
    endtask
    task automatic wr(input logic [5:0] i, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, i, d, x);
        // One more edge so a load launched by the data-phase edge has settled
        @(posedge hclk);
    endtask
    task automatic rchk(input string n, input logic [5:0] i, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, i, 32'h00000000, x);
        chk(n, x, e);
    endtask
    // One sample; outputs settle one edge after it is taken
    task automatic smp(input logic [15:0] c, input logic [15:0] d);
        sample_valid <= 1'b1; c_sample <= c; d_sample <= d;
        @(posedge hclk);
        sample_valid <= 1'b0;
        @(posedge hclk);
    endtask
    // Corrected C: add phase times D scaled by 2^-12, saturated to 16 bits
    function automatic logic [15:0] exp_c(input int c, input int d, input int p);
        int s;
        s = c + ((p * d) >>> 12);
        if (s > 32767) s = 32767;
        if (s < -32768) s = -32768;
        return s[15:0];
    endfunction
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Hang guard, well beyond the roughly 150 cycles the tests need
    initial begin
        #200000;
        errors++;
        tally_and_finish;
    end
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'h0;
        hwdata = 32'h0; sample_valid = 1'b0; c_sample = 16'h0; d_sample = 16'h0; acc = 32'h0;
        seed = 60; errors = 0; checks_done = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk("phase_rst", `QNS_IDX_CD_PHASE, 32'h0);
        rchk("gain_b_rst", `QNS_IDX_CD_GAIN_B, 32'h0400);
        rchk("unmapped", 6'h3f, 32'h0);
        chk("hresp", {31'h0, hresp}, 32'h0);
        $display("reset test done");
        // Sync off: shadows fill, actives wait for the sync command
        ga = $random(seed); gb = $random(seed); r = $random(seed);
        wr(`QNS_IDX_CD_GAIN_A, ga); wr(`QNS_IDX_CD_GAIN_B, gb); wr(`QNS_IDX_CD_PHASE, r);
        chk("ga_act", {16'h0, ga_act}, 32'h0);
        chk("gb_act", {16'h0, gb_act}, 32'h0400);
        rchk("phase_rd", `QNS_IDX_CD_PHASE, {20'h0, r[11:0]});
        wr(`QNS_IDX_SYNC_CMD, 32'h1);
        chk("ga_cmd", {16'h0, ga_act}, {16'h0, ga[15:0]});
        $display("shadow test done");
        // Sync on: companions first, phase last loads the set together
        wr(`QNS_IDX_QUAD_SYNC_EN, 32'h1);
        ga = $random(seed); gb = $random(seed); r = {gb_act, ga_act};
        wr(`QNS_IDX_CD_GAIN_A, ga); wr(`QNS_IDX_CD_GAIN_B, gb);
        chk("held", {gb_act, ga_act}, r);
        wr(`QNS_IDX_CD_PHASE, 32'h0800);
        chk("loaded", {gb_act, ga_act}, {gb[15:0], ga[15:0]});
        // Random phases and samples, saturating corner first
        for (i = 0; i < 12; i++) begin
            r = $random(seed); fr = $random(seed); off = $random(seed);
            if (i == 0) begin r = 32'h800; fr = 32'h7fff; off = 32'h8000; end
            if (i > 0) wr(`QNS_IDX_CD_PHASE, r);
            p = $signed(r[11:0]);
            smp(fr[15:0], off[15:0]);
            chk("c_corr", {16'h0, c_corrected},
                {16'h0, exp_c($signed(fr[15:0]), $signed(off[15:0]), p)});
            chk("d_del", {16'h0, d_delayed}, {16'h0, off[15:0]});
        end
        $display("phase test done");
        // Frequency words wait for the offset write, then the NCO steps
        fr = $random(seed); off = $random(seed);
        wr(`QNS_IDX_AB_FREQ_LO, fr); wr(`QNS_IDX_AB_FREQ_HI, {16'h0, fr[31:16]});
        // Two samples: a wrongly loaded word would show in the address of the second
        smp(16'h0, 16'h0);
        smp(16'h0, 16'h0);
        chk("lut_hold", {16'h0, ab_lut_addr}, 32'h0);
        wr(`QNS_IDX_MIX_SYNC_EN, 32'h1); wr(`QNS_IDX_AB_OFFSET, off);
        for (i = 0; i < 8; i++) begin
            smp(16'h0, 16'h0);
            chk("lut", {16'h0, ab_lut_addr},
                {16'h0, acc[31:16] + off[15:0]});
            acc = acc + fr;
        end
        // A frequency shadow stays pending until the AB sync command loads it
        wr(`QNS_IDX_AB_FREQ_LO, fr ^ 32'h1);
        rchk("ab_pending", `QNS_IDX_SYNC_STATUS, 32'h2);
        wr(`QNS_IDX_SYNC_CMD, 32'h2);
        rchk("ab_synced", `QNS_IDX_SYNC_STATUS, 32'h0);
        rchk("cmd_rd", `QNS_IDX_SYNC_CMD, 32'h0);
        $display("mixer test done");
        tally_and_finish;
    end
endmodule // test_qmc_nco_shadow_autosync
`default_nettype wire
